// >>> rtl/dmx_exec.sv
// The Avalon-MM register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module dmx_exec
    import dmx_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              ce,
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    output dmx_fwr_t               fwr,
    output logic      [7:0]        acc,
    output logic      [6:0]        pc_high_latch,
    output logic      [7:0]        prescale_cfg,
    output logic                   dev_reset_req
);

    // ==================================================
    // Bus handshake
    typedef enum logic {BUS_IDLE, BUS_ACK} dmx_bus_t;

    dmx_bus_t    bus_state;
    logic [15:0] ptr0;
    logic [15:0] ptr1;
    logic [7:0]  flags;
    logic        soft_reset_flag;
    logic [31:0] next_readdata;
    logic        acc_wr;
    logic        exec;
    logic [3:0]  opc;
    logic        psel;
    logic        rel;
    logic [15:0] sel_ptr;
    logic [15:0] ind_eff;
    logic [15:0] ind_nxt;

    // A request is answered one cycle after it is first seen
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_state       <= BUS_IDLE;
            avs_waitrequest <= 1'b1;
        end else if (ce) begin
            case (bus_state)
                BUS_IDLE: begin
                    if (avs_read || avs_write) begin
                        bus_state       <= BUS_ACK;
                        avs_waitrequest <= 1'b0;
                    end
                end
                BUS_ACK: begin
                    bus_state       <= BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
                default: begin
                    bus_state       <= BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // Writes land only at the edge that sees waitrequest low
    assign acc_wr = ce && avs_write && (bus_state == BUS_ACK);
    assign exec   = acc_wr && (avs_address == OFS_INSTR) && (&avs_byteenable[1:0]);

    // ==================================================
    // Instruction fields
    // Opcodes that no decode below names fall through as no-operation
    assign opc     = avs_writedata[OPC_LSB+3:OPC_LSB];
    assign psel    = avs_writedata[PSEL_BIT];
    assign rel     = avs_writedata[REL_BIT];
    assign sel_ptr = psel ? ptr1 : ptr0;

    dmx_ind_addr u_ind (
        .ptr (sel_ptr),
        .upd (avs_writedata[1:0]),
        .rel (rel),
        .ofs (avs_writedata[5:0]),
        .eff (ind_eff),
        .nxt (ind_nxt)
    );

    // ==================================================
    // Accumulator: literal load or bus write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc <= ACC_RST;
        end else if (exec && opc == OP_LD_ACC) begin
            acc <= avs_writedata[7:0];
        end else if (acc_wr && avs_address == OFS_ACC && avs_byteenable[0]) begin
            acc <= avs_writedata[7:0];
        end
    end

    // PC high latch, loaded only by its literal instruction
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_high_latch <= PCH_RST;
        end else if (exec && opc == OP_LD_PCH) begin
            pc_high_latch <= avs_writedata[6:0];
        end
    end

    // Prescaler configuration, loaded from the accumulator
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prescale_cfg <= PRESC_RST;
        end else if (exec && opc == OP_LD_PRESC) begin
            prescale_cfg <= acc;
        end
    end

    // ==================================================
    // Pointers: step on non-relative indirect stores, byte writes from the bus
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr0 <= PTR_RST;
            ptr1 <= PTR_RST;
        end else if (exec && opc == OP_ST_IND) begin
            if (psel) begin
                ptr1 <= ind_nxt;
            end else begin
                ptr0 <= ind_nxt;
            end
        end else if (acc_wr && avs_address == OFS_PTR0) begin
            if (avs_byteenable[0]) ptr0[7:0] <= avs_writedata[7:0];
            if (avs_byteenable[1]) ptr0[15:8] <= avs_writedata[15:8];
        end else if (acc_wr && avs_address == OFS_PTR1) begin
            if (avs_byteenable[0]) ptr1[7:0] <= avs_writedata[7:0];
            if (avs_byteenable[1]) ptr1[15:8] <= avs_writedata[15:8];
        end
    end

    // Status flags: only software touches them, no instruction here does
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags <= FLAGS_RST;
        end else if (acc_wr && avs_address == OFS_FLAGS && avs_byteenable[0]) begin
            flags <= avs_writedata[7:0];
        end
    end

    // ==================================================
    // File write port, one cycle pulse per store
    // The ports hold no data; a direct store to one goes to its pointer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fwr <= '0;
        end else if (ce) begin
            fwr.valid <= 1'b0;
            if (exec && opc == OP_ST_FILE) begin
                fwr.valid <= 1'b1;
                fwr.addr  <= dmx_file_addr(avs_writedata[6:0], ptr0, ptr1);
                fwr.data  <= acc;
            end else if (exec && opc == OP_ST_IND) begin
                fwr.valid <= 1'b1;
                fwr.addr  <= ind_eff;
                fwr.data  <= acc;
            end
        end
    end

    // ==================================================
    // Software reset: one pulse out, cause flag cleared
    // Software sets the flag again after it has seen the cause
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            soft_reset_flag <= SRST_RST;
            dev_reset_req   <= 1'b0;
        end else if (ce) begin
            dev_reset_req <= exec && (opc == OP_SOFT_RST);
            if (exec && opc == OP_SOFT_RST) begin
                soft_reset_flag <= 1'b0;
            end else if (acc_wr && avs_address == OFS_PWRCTL && avs_byteenable[0]) begin
                soft_reset_flag <= avs_writedata[SRST_BIT];
            end
        end
    end

    // ==================================================
    // Read path; unmapped offsets read as zero
    always_comb begin
        next_readdata = 32'h0000_0000;
        case (avs_address)
            OFS_ACC:    next_readdata[7:0]  = acc;
            OFS_PCH:    next_readdata[6:0]  = pc_high_latch;
            OFS_PTR0:   next_readdata[15:0] = ptr0;
            OFS_PTR1:   next_readdata[15:0] = ptr1;
            OFS_PRESC:  next_readdata[7:0]  = prescale_cfg;
            OFS_FLAGS:  next_readdata[7:0]  = flags;
            OFS_PWRCTL: next_readdata[SRST_BIT] = soft_reset_flag;
            default:    next_readdata = 32'h0000_0000;
        endcase
    end

    // Captured while waiting, so data stand at the answering edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (ce && bus_state == BUS_IDLE && avs_read) begin
            avs_readdata <= next_readdata;
        end
    end

    // ==================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_op(logic [3:0] o);
        exec && opc == o;
    endsequence

    sequence s_soft_reset_out;
        dev_reset_req && !soft_reset_flag ##1 !dev_reset_req;
    endsequence

    a_pch_literal_load: assert property (
        s_op(OP_LD_PCH) |=> pc_high_latch == $past(avs_writedata[6:0]) && $stable(flags))
        else $error("pc high latch not loaded from literal");

    a_acc_literal_load: assert property (
        s_op(OP_LD_ACC) |=> acc == $past(avs_writedata[7:0]) && $stable(flags))
        else $error("accumulator not loaded from literal");

    a_file_store_word: assert property (
        s_op(OP_ST_FILE) ##0 (avs_writedata[6:1] != 6'h00)
        |=> fwr.valid && fwr.data == $past(acc)
            && fwr.addr == {9'h000, $past(avs_writedata[6:0])})
        else $error("direct store wrong");

    a_ind_pre_inc: assert property (
        s_op(OP_ST_IND) ##0 (!rel && avs_writedata[1:0] == UPD_PRE_INC)
        |=> fwr.valid && fwr.addr == $past(sel_ptr) + 16'h0001)
        else $error("pre-increment address wrong");

    a_ind_post_dec: assert property (
        s_op(OP_ST_IND) ##0 (!rel && avs_writedata[1:0] == UPD_POST_DEC)
        |=> fwr.addr == $past(sel_ptr) && sel_ptr == $past(sel_ptr) - 16'h0001)
        else $error("post-decrement wrong");

    a_rel_ptr_keep: assert property (
        s_op(OP_ST_IND) ##0 rel
        |=> sel_ptr == $past(sel_ptr)
            && fwr.addr == $past(sel_ptr) + {{10{$past(avs_writedata[5])}},
                                             $past(avs_writedata[5:0])})
        else $error("relative store wrong");

    a_ptr_inc_step: assert property (
        s_op(OP_ST_IND) ##0 (!rel && !avs_writedata[0])
        |=> sel_ptr == $past(sel_ptr) + 16'h0001)
        else $error("pointer did not step up by one");

    a_port_redirect: assert property (
        s_op(OP_ST_FILE) ##0 (avs_writedata[6:0] == IND1_PORT)
        |=> fwr.valid && fwr.addr == $past(ptr1))
        else $error("indirect port not redirected");

    a_ind_flags_hold: assert property (
        s_op(OP_ST_IND) |=> $stable(flags) [*2])
        else $error("indirect store changed flags");

    a_presc_load: assert property (
        s_op(OP_LD_PRESC) |=> prescale_cfg == $past(acc) && $stable(flags))
        else $error("prescaler configuration not loaded");

    a_soft_reset_seq: assert property (
        s_op(OP_SOFT_RST) ##1 ce |-> s_soft_reset_out)
        else $error("software reset pulse or flag wrong");

    a_nop_quiet: assert property (
        s_op(OP_NOP) |=> !fwr.valid && $stable(acc) && $stable(ptr0)
                         && $stable(ptr1) && $stable(pc_high_latch))
        else $error("no-operation changed state");

    // ==================================================
    // Hold, pulse, pointer step and port redirect checks
    // Registers that only one instruction may load must not drift
    a_pch_hold_other: assert property (
        !(exec && opc == OP_LD_PCH) |=> $stable(pc_high_latch))
        else $error("pc high latch changed without its instruction");

    a_presc_hold_other: assert property (
        !(exec && opc == OP_LD_PRESC) |=> $stable(prescale_cfg))
        else $error("prescaler configuration changed without its instruction");

    a_flags_any_instr: assert property (
        exec |=> $stable(flags))
        else $error("an instruction changed the flags");

    a_store_one_pulse: assert property (
        fwr.valid && ce |=> !fwr.valid)
        else $error("store pulse longer than one cycle");

    a_ind_pre_dec: assert property (
        s_op(OP_ST_IND) ##0 (!rel && avs_writedata[1:0] == UPD_PRE_DEC)
        |=> fwr.valid && fwr.addr == $past(sel_ptr) - 16'h0001)
        else $error("pre-decrement address wrong");

    a_ind_post_inc: assert property (
        s_op(OP_ST_IND) ##0 (!rel && avs_writedata[1:0] == UPD_POST_INC)
        |=> fwr.addr == $past(sel_ptr) && sel_ptr == $past(sel_ptr) + 16'h0001)
        else $error("post-increment wrong");

    a_ptr_dec_step: assert property (
        s_op(OP_ST_IND) ##0 (!rel && avs_writedata[0])
        |=> sel_ptr == $past(sel_ptr) - 16'h0001)
        else $error("pointer did not step down by one");

    a_port0_redirect: assert property (
        s_op(OP_ST_FILE) ##0 (avs_writedata[6:0] == IND0_PORT)
        |=> fwr.valid && fwr.addr == $past(ptr0))
        else $error("indirect port 0 not redirected");

    // A reset request may only follow the instruction, never a bus write
    a_reset_req_cause: assert property (
        dev_reset_req && $past(ce)
        |-> $past(exec) && $past(opc) == OP_SOFT_RST)
        else $error("reset request without its instruction");

    // Spare opcodes must behave exactly like a no-operation
    a_spare_op_quiet: assert property (
        exec && opc > OP_SOFT_RST
        |=> !fwr.valid && !dev_reset_req && $stable(acc) && $stable(ptr0) && $stable(ptr1))
        else $error("spare opcode changed state");

    // With the enable low nothing moves, the bus answer included
    a_ce_freeze_all: assert property (
        !ce |=> $stable(flags) && $stable(acc) && $stable(ptr0) && $stable(ptr1)
                 && $stable(fwr) && $stable(avs_waitrequest) && $stable(dev_reset_req))
        else $error("state moved while the clock enable was low");

endmodule

// >>> rtl/dmx_ind_addr.sv
`timescale 1ns/1ps
module dmx_ind_addr
    import dmx_pkg::*;
(
    input  wire logic [15:0] ptr,
    input  wire logic [1:0]  upd,
    input  wire logic        rel,
    input  wire logic [5:0]  ofs,
    output logic      [15:0] eff,
    output logic      [15:0] nxt
);

    // ==================================================
    // Effective address and next pointer value
    // 16-bit sums wrap on their own, which is the wanted behaviour
    always_comb begin
        eff = ptr;
        nxt = ptr;
        if (rel) begin
            eff = ptr + {{10{ofs[5]}}, ofs};
        end else begin
            case (upd)
                UPD_PRE_INC: begin
                    eff = ptr + 16'h0001;
                    nxt = ptr + 16'h0001;
                end
                UPD_PRE_DEC: begin
                    eff = ptr - 16'h0001;
                    nxt = ptr - 16'h0001;
                end
                UPD_POST_INC: nxt = ptr + 16'h0001;
                default:      nxt = ptr - 16'h0001;
            endcase
        end
    end

endmodule

// >>> rtl/dmx_pkg.sv
package dmx_pkg;

    // ==================================================
    // Register map (byte addresses, one word each)
    localparam int         ADDR_W       = 8;
    localparam logic [7:0] OFS_INSTR    = 8'h00;
    localparam logic [7:0] OFS_ACC      = 8'h04;
    localparam logic [7:0] OFS_PCH      = 8'h08;
    localparam logic [7:0] OFS_PTR0     = 8'h0C;
    localparam logic [7:0] OFS_PTR1     = 8'h10;
    localparam logic [7:0] OFS_PRESC    = 8'h14;
    localparam logic [7:0] OFS_FLAGS    = 8'h18;
    localparam logic [7:0] OFS_PWRCTL   = 8'h1C;

    // ==================================================
    // Instruction word fields
    localparam int         OPC_LSB      = 12;
    localparam int         PSEL_BIT     = 8;
    localparam int         REL_BIT      = 9;
    localparam int         SRST_BIT     = 0;
    localparam logic [3:0] OP_NOP       = 4'h0;
    localparam logic [3:0] OP_LD_PCH    = 4'h1;
    localparam logic [3:0] OP_LD_ACC    = 4'h2;
    localparam logic [3:0] OP_ST_FILE   = 4'h3;
    localparam logic [3:0] OP_ST_IND    = 4'h4;
    localparam logic [3:0] OP_LD_PRESC  = 4'h5;
    localparam logic [3:0] OP_SOFT_RST  = 4'h6;

    // Pointer update codes
    localparam logic [1:0] UPD_PRE_INC  = 2'h0;
    localparam logic [1:0] UPD_PRE_DEC  = 2'h1;
    localparam logic [1:0] UPD_POST_INC = 2'h2;
    localparam logic [1:0] UPD_POST_DEC = 2'h3;

    // File addresses of the two indirect access ports
    localparam logic [6:0] IND0_PORT    = 7'h00;
    localparam logic [6:0] IND1_PORT    = 7'h01;

    // ==================================================
    // Values after reset
    localparam logic [7:0]  ACC_RST     = 8'h00;
    localparam logic [6:0]  PCH_RST     = 7'h00;
    localparam logic [15:0] PTR_RST     = 16'h0000;
    localparam logic [7:0]  PRESC_RST   = 8'hFF;
    localparam logic [7:0]  FLAGS_RST   = 8'h00;
    localparam logic        SRST_RST    = 1'b1;

    // File register write port
    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
        logic [7:0]  data;
    } dmx_fwr_t;

    // Direct address, or the pointer when an indirect port is named
    function automatic logic [15:0] dmx_file_addr(input logic [6:0]  f,
                                                  input logic [15:0] p0,
                                                  input logic [15:0] p1);
        if (f == IND0_PORT) begin
            return p0;
        end else if (f == IND1_PORT) begin
            return p1;
        end
        return {9'h000, f};
    endfunction

endpackage

// >>> sim/dmx_exec_tb.sv
`timescale 1ns/1ps
module dmx_exec_tb
    import dmx_pkg::*;
;
    // ==================================================
    // Signals and reference model state
    logic        clk;
    logic        rst_n;
    logic        ce;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    dmx_fwr_t    fwr;
    logic [7:0]  acc;
    logic [6:0]  pc_high_latch;
    logic [7:0]  prescale_cfg;
    logic        dev_reset_req;
    int          bad_count;
    int          n_tests;
    logic [31:0] seed;
    logic [7:0]  m_acc;
    logic [6:0]  m_pch;
    logic [15:0] m_p0;
    logic [15:0] m_p1;
    logic [7:0]  m_presc;
    logic [7:0]  m_flags;
    logic        stall;

    dmx_exec u_dut (
        .clk             (clk),
        .rst_n           (rst_n),
        .ce              (ce),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .fwr             (fwr),
        .acc             (acc),
        .pc_high_latch   (pc_high_latch),
        .prescale_cfg    (prescale_cfg),
        .dev_reset_req   (dev_reset_req)
    );

    // 50 MHz clock
    always #10 clk = ~clk;

    // ==================================================
    // Helpers
    task automatic complete_run();
        if (bad_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Xorshift keeps the run repeatable without simulator seeds
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Effective address in the upper half, pointer afterwards in the lower
    function automatic logic [31:0] ind_of(input logic [15:0] p, input logic rel,
                                           input logic [1:0] u, input logic [5:0] k);
        if (rel) begin
            return {p + {{10{k[5]}}, k}, p};
        end
        case (u)
            UPD_PRE_INC:  return {p + 16'h0001, p + 16'h0001};
            UPD_PRE_DEC:  return {p - 16'h0001, p - 16'h0001};
            UPD_POST_INC: return {p, p + 16'h0001};
            default:      return {p, p - 16'h0001};
        endcase
    endfunction

    // One Avalon transfer; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        int i;
        @(posedge clk);
        avs_write      <= wr;
        avs_read       <= ~wr;
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        // Stall with the enable low before the request is seen; never during the answer
        if (stall) begin
            ce <= 1'b0;
            repeat (3) @(posedge clk);
            ce <= 1'b1;
        end
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) break;
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (i == 20) begin
            bad_count++;
            complete_run();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] q;
        bus(1'b1, a, d, be, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'hF, q);
        chk(q & m, e);
    endtask

    // Reset pulse of two cycles; the model returns to its reset values
    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n   <= 1'b1;
        m_acc   = ACC_RST;
        m_pch   = PCH_RST;
        m_p0    = PTR_RST;
        m_p1    = PTR_RST;
        m_presc = PRESC_RST;
        m_flags = FLAGS_RST;
    endtask

    task automatic chk_defaults();
        rd(OFS_ACC, {24'h0, ACC_RST}, 32'hFFFFFFFF);
        rd(OFS_PCH, {25'h0, PCH_RST}, 32'hFFFFFFFF);
        rd(OFS_PTR0, {16'h0, PTR_RST}, 32'hFFFFFFFF);
        rd(OFS_PTR1, {16'h0, PTR_RST}, 32'hFFFFFFFF);
        rd(OFS_PRESC, {24'h0, PRESC_RST}, 32'hFFFFFFFF);
        rd(OFS_FLAGS, {24'h0, FLAGS_RST}, 32'hFFFFFFFF);
        rd(OFS_PWRCTL, {31'h0, SRST_RST}, 32'h00000001);
        rd(8'h20, 32'h0, 32'hFFFFFFFF);
    endtask

    // Issue one instruction and compare every result port with the model
    task automatic exe(input logic [15:0] w);
        logic [3:0]  op;
        logic [31:0] r;
        logic [15:0] ea;
        logic        st;
        op = w[15:12];
        st = 1'b0;
        ea = 16'h0000;
        r  = ind_of(w[8] ? m_p1 : m_p0, w[9], w[1:0], w[5:0]);
        case (op)
            OP_LD_PCH:   m_pch = w[6:0];
            OP_LD_ACC:   m_acc = w[7:0];
            OP_LD_PRESC: m_presc = m_acc;
            OP_ST_FILE: begin
                st = 1'b1;
                ea = (w[6:0] == IND0_PORT) ? m_p0 :
                     (w[6:0] == IND1_PORT) ? m_p1 : {9'h000, w[6:0]};
            end
            OP_ST_IND: begin
                st = 1'b1;
                ea = r[31:16];
                if (w[8]) m_p1 = r[15:0];
                else m_p0 = r[15:0];
            end
            default: ;
        endcase
        wr(OFS_INSTR, {16'h0, w}, 4'hF);
        #1;
        chk(32'(acc), 32'(m_acc));
        chk(32'(pc_high_latch), 32'(m_pch));
        chk(32'(prescale_cfg), 32'(m_presc));
        chk(32'(fwr.valid), 32'(st));
        chk(32'(dev_reset_req), 32'(op == OP_SOFT_RST));
        if (st) begin
            chk(32'(fwr.addr), 32'(ea));
            chk(32'(fwr.data), 32'(m_acc));
        end
        if (op == OP_SOFT_RST) begin
            rd(OFS_PWRCTL, 32'h0, 32'h00000001);
            wr(OFS_PWRCTL, 32'h00000001, 4'hF);
        end
    endtask

    // ==================================================
    // Main sequence
    initial begin
        logic [31:0] r;
        clk = 1'b0;
        rst_n = 1'b0;
        ce = 1'b1;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        bad_count = 0;
        n_tests = 0;
        seed = 32'd96995;
        stall = 1'b0;
        do_reset();
        chk_defaults();
        wr(OFS_FLAGS, 32'h000000A5, 4'hF);
        m_flags = 8'hA5;
        // Literal bounds; the upper bits of the PC high field are not literal bits
        exe({OP_LD_PCH, 12'hFFF});
        exe({OP_LD_ACC, 12'h0FF});
        exe({OP_ST_FILE, 12'h07F});
        exe({OP_LD_PRESC, 12'h000});
        // Pointer wrap at both ends
        wr(OFS_PTR0, 32'h0000FFFF, 4'h3);
        m_p0 = 16'hFFFF;
        exe({OP_ST_IND, 4'h0, 8'h00});
        exe({OP_ST_IND, 4'h1, 8'h03});
        rd(OFS_PTR0, {16'h0, m_p0}, 32'hFFFFFFFF);
        rd(OFS_PTR1, {16'h0, m_p1}, 32'hFFFFFFFF);
        // Relative offset extremes leave pointers alone
        exe({OP_ST_IND, 4'h2, 8'h20});
        exe({OP_ST_IND, 4'h3, 8'h1F});
        rd(OFS_PTR1, {16'h0, m_p1}, 32'hFFFFFFFF);
        for (int u = 0; u < 4; u++) begin
            exe({OP_ST_IND, 4'h0, 6'h00, 2'(u)});
        end
        exe({OP_ST_FILE, 5'h00, IND0_PORT});
        exe({OP_ST_FILE, 5'h00, IND1_PORT});
        exe({OP_NOP, 12'hABC});
        // Refused writes change nothing
        wr(OFS_PCH, 32'h00000055, 4'hF);
        wr(OFS_PRESC, 32'h00000000, 4'hF);
        wr(8'h20, 32'hFFFFFFFF, 4'hF);
        wr(OFS_INSTR, {16'h0, OP_LD_ACC, 12'h033}, 4'h1);
        #1;
        chk(32'(acc), 32'(m_acc));
        rd(OFS_PCH, {25'h0, m_pch}, 32'hFFFFFFFF);
        rd(OFS_PRESC, {24'h0, m_presc}, 32'hFFFFFFFF);
        rd(8'h20, 32'h0, 32'hFFFFFFFF);
        // Only the enabled byte lane of a pointer is written
        wr(OFS_PTR0, 32'h00001234, 4'h1);
        m_p0 = {m_p0[15:8], 8'h34};
        rd(OFS_PTR0, {16'h0, m_p0}, 32'hFFFFFFFF);
        // Random mix of instructions and register loads
        for (int n = 0; n < 300; n++) begin
            r = rnd();
            stall = (r[27:26] == 2'h3);
            if (r[31:29] == 3'h0) begin
                wr(OFS_ACC, {24'h0, r[7:0]}, 4'hF);
                m_acc = r[7:0];
            end else if (r[31:29] == 3'h1) begin
                wr(r[28] ? OFS_PTR1 : OFS_PTR0, {16'h0, r[15:0]}, 4'h3);
                if (r[28]) m_p1 = r[15:0];
                else m_p0 = r[15:0];
            end else begin
                exe({1'b0, r[18:16], r[11:0]});
            end
            if (n % 16 == 15) begin
                rd(OFS_PTR0, {16'h0, m_p0}, 32'hFFFFFFFF);
                rd(OFS_PTR1, {16'h0, m_p1}, 32'hFFFFFFFF);
                rd(OFS_ACC, {24'h0, m_acc}, 32'hFFFFFFFF);
            end
        end
        stall = 1'b0;
        // Flags survive every instruction class
        rd(OFS_FLAGS, {24'h0, m_flags}, 32'hFFFFFFFF);
        // Second reset in mid-run
        do_reset();
        chk_defaults();
        complete_run();
    end
endmodule
